// File: verilog/phy_extended_control_two.sv
`timescale 1ns/1ps
module phy_extended_control_two import ext_ctrl2_pkg::*; #(
  parameter logic [SQE_CNT_W-1:0] SQE_DELAY = SQE_DELAY_CYC,
  parameter logic [SQE_CNT_W-1:0] SQE_PULSE = SQE_PULSE_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Strap pins
  input wire logic node_repeater_strap,
  input wire logic pin_register_priority_strap,
  // Transmit enable pin from the MAC
  input wire logic tx_en,
  // Link state from the rest of the PHY, same clock
  input wire logic link_is_100,
  input wire logic full_duplex,
  input wire logic rx_activity,
  input wire logic line_collision,
  input wire logic partner_link_fault,
  input wire logic isolate,
  input wire logic sqe_inhibit,
  // Media independent interface status
  output logic carrier_sense,
  output logic collision,
  // Transceiver power control
  output logic power_down_10,
  output logic power_down_100,
  // Mode outputs
  output logic repeater_mode,
  output logic register_priority,
  output logic sqe_default_enable,
  output logic sqe_test_active
);

  typedef struct packed {
    strap_state_e state;
    logic [1:0] settle_cnt;
    logic repeater;
    logic sw_priority;
    logic remote_fault;
    logic auto_pd10;
    logic auto_pd100;
    logic [DATA_W-1:0] rdata;
    logic crs;
    logic col;
    logic pd10;
    logic pd100;
    logic sqe_default;
    logic sqe_en;
  } ctl_s;

  ctl_s st_ff;
  ctl_s nxt_st;

  logic [2:0] pins_sync;
  logic node_rep_s;
  logic prio_s;
  logic tx_en_s;
  logic reg_hit;
  logic [DATA_W-1:0] read_word;

  sqe_if sq ();

  // Straps and transmit enable come from pins, so synchronise them first
  sync2 #(
    .W(3)
  ) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in({node_repeater_strap, pin_register_priority_strap, tx_en}),
    .sync_out(pins_sync)
  );

  assign node_rep_s = pins_sync[2];
  assign prio_s = pins_sync[1];
  assign tx_en_s = pins_sync[0];

  // Collision test generator sits on the synchronised transmit enable
  sqe_pulse_gen #(
    .DELAY_CYC(SQE_DELAY),
    .PULSE_CYC(SQE_PULSE)
  ) u_sqe (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sq(sq.gen)
  );

  assign sq.tx_en = tx_en_s;
  assign sq.test_en = st_ff.sqe_en;

  // Only one register lives here, so a full address compare suffices
  assign reg_hit = (reg_addr == EC2_ADDR);

  // Read image: reserved field forced to zero, never stored
  always_comb begin
    read_word = '0;
    read_word[NODE_REP_BIT] = st_ff.repeater;
    read_word[PRIO_BIT] = st_ff.sw_priority;
    read_word[RFAULT_BIT] = st_ff.remote_fault;
    read_word[RSVD_HI:RSVD_LO] = RSVD_VALUE;
    read_word[AUTO_PD10_BIT] = st_ff.auto_pd10;
    read_word[AUTO_PD100_BIT] = st_ff.auto_pd100;
  end

  // Next-state logic for every flip-flop of the block
  always_comb begin
    nxt_st = st_ff;

    // Straps are taken once the synchroniser has filled after reset
    unique case (st_ff.state)
      ST_SETTLE: begin
        if (st_ff.settle_cnt == STRAP_SETTLE_CYC) begin
          nxt_st.state = ST_RUN;
          nxt_st.repeater = node_rep_s;
          nxt_st.sw_priority = prio_s;
        end else begin
          nxt_st.settle_cnt = st_ff.settle_cnt + 1'b1;
        end
      end
      ST_RUN: begin
        // Straps hold their sampled level until the next reset
        nxt_st.settle_cnt = st_ff.settle_cnt;
      end
    endcase

    // Remote fault follows the partner's control word every cycle
    nxt_st.remote_fault = partner_link_fault;

    // Only the two enables accept writes; bits 15 to 13 and the
    // reserved field are dropped, which keeps their read values intact
    if (reg_wr && reg_hit) begin
      nxt_st.auto_pd10 = reg_wdata[AUTO_PD10_BIT];
      nxt_st.auto_pd100 = reg_wdata[AUTO_PD100_BIT];
    end

    // Read data stand for one cycle only, zero otherwise
    if (reg_rd && reg_hit) begin
      nxt_st.rdata = read_word;
    end else begin
      nxt_st.rdata = RDATA_IDLE;
    end

    // Carrier sense depends on the sampled mode
    if (st_ff.repeater) begin
      nxt_st.crs = rx_activity;
    end else begin
      nxt_st.crs = rx_activity | tx_en_s;
    end

    // Test default follows mode; inhibit bit elsewhere can still veto
    nxt_st.sqe_default = ~st_ff.repeater;

    // Test runs only at 10 Mb/s half duplex in node mode, while powered
    nxt_st.sqe_en = st_ff.sqe_default & ~sqe_inhibit & ~full_duplex &
                    ~st_ff.repeater & ~link_is_100 & ~st_ff.pd10;

    // Test pulse merged with the real collision indication
    nxt_st.col = line_collision | sq.pulse;

    // Automatic power-down, overridden by isolate
    nxt_st.pd10 = isolate | (st_ff.auto_pd10 & link_is_100);
    nxt_st.pd100 = isolate |
                   (st_ff.auto_pd100 & ~link_is_100);
  end

  // Register all state; straps read zero until sampled
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_ff <= '{state: ST_SETTLE,
                 settle_cnt: 2'h0,
                 repeater: 1'b0,
                 sw_priority: 1'b0,
                 remote_fault: RFAULT_RST,
                 auto_pd10: AUTO_PD10_RST,
                 auto_pd100: AUTO_PD100_RST,
                 rdata: RDATA_IDLE,
                 crs: 1'b0,
                 col: 1'b0,
                 pd10: 1'b0,
                 pd100: 1'b0,
                 sqe_default: 1'b1,
                 sqe_en: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Every output straight from a flip-flop
  assign reg_rdata = st_ff.rdata;
  assign carrier_sense = st_ff.crs;
  assign collision = st_ff.col;
  assign power_down_10 = st_ff.pd10;
  assign power_down_100 = st_ff.pd100;
  assign repeater_mode = st_ff.repeater;
  assign register_priority = st_ff.sw_priority;
  assign sqe_default_enable = st_ff.sqe_default;
  assign sqe_test_active = st_ff.sqe_en;

endmodule

// File: verilog/ext_ctrl2_pkg.sv
package ext_ctrl2_pkg;

  // Register port geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // Register offset of the extended control two register
  localparam logic [ADDR_W-1:0] EC2_ADDR = 5'h13;

  // Field positions
  localparam int NODE_REP_BIT = 15;
  localparam int PRIO_BIT = 14;
  localparam int RFAULT_BIT = 13;
  localparam int RSVD_HI = 12;
  localparam int RSVD_LO = 2;
  localparam int AUTO_PD10_BIT = 1;
  localparam int AUTO_PD100_BIT = 0;

  // Reset values
  localparam logic AUTO_PD10_RST = 1'b1;
  localparam logic AUTO_PD100_RST = 1'b1;
  localparam logic RFAULT_RST = 1'b0;
  localparam logic [RSVD_HI-RSVD_LO:0] RSVD_VALUE = 11'h000;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 16'h0000;

  // Timing: clock rate and signal quality error test timing
  localparam int SYS_CLK_MHZ = 40;
  localparam int SQE_DELAY_NS = 1000;
  localparam int SQE_PULSE_NS = 1000;
  localparam int SQE_CNT_W = 8;
  localparam logic [SQE_CNT_W-1:0] SQE_DELAY_CYC =
    SQE_CNT_W'((SQE_DELAY_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam logic [SQE_CNT_W-1:0] SQE_PULSE_CYC =
    SQE_CNT_W'((SQE_PULSE_NS * SYS_CLK_MHZ + 999) / 1000);

  // Edges after reset release before synchronised straps are valid
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'h2;

  // Strap capture sequence
  typedef enum logic {ST_SETTLE, ST_RUN} strap_state_e;

  // Collision test sequence
  typedef enum logic [1:0] {SQ_IDLE, SQ_TX, SQ_WAIT, SQ_PULSE} sqe_state_e;

endpackage

// File: verilog/sqe_if.sv
`timescale 1ns/1ps
// Link between the register block and the collision test generator
interface sqe_if;
  logic tx_en;
  logic test_en;
  logic pulse;

  modport ctrl (output tx_en, output test_en, input pulse);
  modport gen (input tx_en, input test_en, output pulse);
endinterface

// File: verilog/sync2.sv
`timescale 1ns/1ps
module sync2 import ext_ctrl2_pkg::*; #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;

  sync_s st_ff;
  sync_s nxt_st;

  // First stage is read only by the second stage
  always_comb begin
    nxt_st.meta = async_in;
    nxt_st.stable = st_ff.meta;
  end

  // Synchronous reset clears both stages
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.stable;

endmodule

// File: verilog/sqe_pulse_gen.sv
`timescale 1ns/1ps
module sqe_pulse_gen import ext_ctrl2_pkg::*; #(
  parameter logic [SQE_CNT_W-1:0] DELAY_CYC = SQE_DELAY_CYC,
  parameter logic [SQE_CNT_W-1:0] PULSE_CYC = SQE_PULSE_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Control side
  sqe_if.gen sq
);

  typedef struct packed {
    sqe_state_e state;
    logic [SQE_CNT_W-1:0] cnt;
    logic pulse;
  } sqe_s;

  sqe_s st_ff;
  sqe_s nxt_st;

  // One pulse per transmitted packet, after transmit enable falls
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff.state)
      SQ_IDLE: begin
        nxt_st.pulse = 1'b0;
        if (sq.tx_en && sq.test_en) begin
          nxt_st.state = SQ_TX;
        end
      end
      SQ_TX: begin
        if (!sq.tx_en) begin
          nxt_st.state = SQ_WAIT;
          nxt_st.cnt = DELAY_CYC - 1'b1;
        end
      end
      SQ_WAIT: begin
        if (st_ff.cnt == '0) begin
          nxt_st.state = SQ_PULSE;
          nxt_st.cnt = PULSE_CYC - 1'b1;
          nxt_st.pulse = 1'b1;
        end else begin
          nxt_st.cnt = st_ff.cnt - 1'b1;
        end
      end
      SQ_PULSE: begin
        if (st_ff.cnt == '0) begin
          nxt_st.state = SQ_IDLE;
          nxt_st.pulse = 1'b0;
        end else begin
          nxt_st.cnt = st_ff.cnt - 1'b1;
        end
      end
    endcase
    // Losing the enable mid-sequence aborts at once, cutting any pulse under way short
    if (!sq.test_en) begin
      nxt_st.state = SQ_IDLE;
      nxt_st.pulse = 1'b0;
      nxt_st.cnt = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_ff <= '{state: SQ_IDLE, cnt: '0, pulse: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sq.pulse = st_ff.pulse;

endmodule

// File: verif/phy_ec2_props.sv
`timescale 1ns/1ps
module phy_ec2_props import ext_ctrl2_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Link state
  input wire logic rx_activity,
  input wire logic partner_link_fault,
  input wire logic isolate,
  input wire logic link_is_100,
  input wire logic full_duplex,
  // Status outputs
  input wire logic carrier_sense,
  input wire logic power_down_10,
  input wire logic power_down_100,
  input wire logic repeater_mode,
  input wire logic register_priority,
  input wire logic sqe_default_enable,
  input wire logic sqe_test_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Mapped read; the word shows in the next cycle
  wire logic rd13 = reg_rd && reg_addr == EC2_ADDR;
  // Reserved field must be zero even outside read cycles
  property p_rsvd; reg_rdata[RSVD_HI:RSVD_LO] == '0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved set");
  property p_strap; rd13 |=> reg_rdata[15:14] ==
    $past({repeater_mode, register_priority}); endproperty
  a_strap: assert property (p_strap) else $error("strap bits");
  // Fault must be steady for two samples, as the mirror lags one cycle
  property p_rf; rd13 && $stable(partner_link_fault) |=>
    reg_rdata[13] == $past(partner_link_fault, 2); endproperty
  a_rf: assert property (p_rf) else $error("fault bit");
  property p_iso; isolate |=> power_down_10 && power_down_100; endproperty
  a_iso: assert property (p_iso) else $error("isolate");
  property p_pd10; !isolate && !link_is_100 |=> !power_down_10; endproperty
  a_pd10: assert property (p_pd10) else $error("pd10");
  property p_pd100; !isolate && link_is_100 |=> !power_down_100; endproperty
  a_pd100: assert property (p_pd100) else $error("pd100");
  property p_crs_rep; repeater_mode |=>
    carrier_sense == $past(rx_activity); endproperty
  a_crs_rep: assert property (p_crs_rep) else $error("crs rep");
  property p_crs_node; !repeater_mode && rx_activity |=> carrier_sense;
  endproperty
  a_crs_node: assert property (p_crs_node) else $error("crs");
  property p_sqe_off; (full_duplex || repeater_mode) [*2] |=>
    !sqe_test_active; endproperty
  a_sqe_off: assert property (p_sqe_off) else $error("sqe on");
  // Test default is the inverse of the mode one cycle earlier
  property p_sqe_def; sqe_default_enable == !$past(repeater_mode);
  endproperty
  a_sqe_def: assert property (p_sqe_def) else $error("sqe def");
endmodule

bind phy_extended_control_two phy_ec2_props u_props (.sys_clk, .nrst,
  .reg_addr, .reg_rd, .reg_rdata, .rx_activity, .partner_link_fault,
  .isolate, .link_is_100, .full_duplex, .carrier_sense, .power_down_10,
  .power_down_100, .repeater_mode, .register_priority, .sqe_default_enable,
  .sqe_test_active);

// File: verif/mgmt_station.sv
`timescale 1ns/1ps
module mgmt_station import ext_ctrl2_pkg::*; (
  // Clock
  input wire logic sys_clk,
  // Register port toward the device
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // Idle bus; address is scrambled after reads, write data after writes
  initial begin
    reg_addr = 5'h1F;
    reg_wdata = 16'hFFFF;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Reserved field always carries its default on a write
  task automatic wr(input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_addr <= EC2_ADDR;
    reg_wdata <= {d[15:13], RSVD_VALUE, d[1:0]};
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  endtask
endmodule

// File: verif/test_phy_extended_control_two.sv
`timescale 1ns/1ps
module test_phy_extended_control_two import ext_ctrl2_pkg::*;;
  logic sys_clk, nrst, node_repeater_strap, pin_register_priority_strap;
  logic tx_en, link_is_100, full_duplex, rx_activity, line_collision;
  logic partner_link_fault, isolate, sqe_inhibit, rd_d, probe, reg_wr;
  logic reg_rd, carrier_sense, collision, power_down_10, power_down_100;
  logic repeater_mode, register_priority, sqe_default_enable;
  logic sqe_test_active;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d, got, exp;
  logic [DATA_W-1:0] q[$];
  int fails, n_checks, seed, i, n;
  mgmt_station u_mgmt_station (.sys_clk, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd);
  // Short test timing keeps the collision test quick
  localparam int TEST_PULSE = 3;
  phy_extended_control_two #(.SQE_DELAY(8'h02),
    .SQE_PULSE(TEST_PULSE[7:0]))
    u_phy_extended_control_two (.sys_clk, .nrst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .node_repeater_strap,
    .pin_register_priority_strap, .tx_en, .link_is_100, .full_duplex,
    .rx_activity, .line_collision, .partner_link_fault, .isolate,
    .sqe_inhibit, .carrier_sense, .collision, .power_down_10,
    .power_down_100, .repeater_mode, .register_priority,
    .sqe_default_enable, .sqe_test_active);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Compare just after the falling edge, clear of register updates
  always @(posedge sys_clk) rd_d <= reg_rd;
  always @(negedge sys_clk) begin
    #1;
    if (rd_d || probe) begin
      got = rd_d ? reg_rdata : {12'h000, power_down_10, power_down_100,
        carrier_sense, collision};
      exp = (q.size() != 0) ? q.pop_front() : 16'hXXXX;
      n_checks++;
      if (got !== exp) begin
        fails++;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
    q.push_back(e);
    u_mgmt_station.rd(a);
  endtask
  // Extra edge first so a probe never meets a read result
  task automatic chk(input logic [3:0] e);
    q.push_back({12'h000, e});
    @(posedge sys_clk);
    @(negedge sys_clk);
    probe = 1'b1;
    @(posedge sys_clk);
    probe = 1'b0;
  endtask
  // Collision cycles seen after a frame against the expected count
  task automatic cnt_chk(input int want);
    n_checks++;
    if (n != want) begin
      fails++;
      $display("unexpected at %0t: %0d collision cycles, want %0d",
        $time, n, want);
    end
  endtask
  task automatic do_reset(input logic rep);
    @(posedge sys_clk);
    nrst <= 1'b0;
    node_repeater_strap <= rep;
    {tx_en, link_is_100, full_duplex, rx_activity} <= 4'h0;
    {line_collision, partner_link_fault, isolate} <= 3'h0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge sys_clk);
  endtask
  // Send one frame and count collision cycles after it
  task automatic frame;
    @(posedge sys_clk);
    tx_en <= 1'b1;
    repeat (4) @(posedge sys_clk);
    tx_en <= 1'b0;
    n = 0;
    // An unknown collision level counts as a pulse, never as quiet
    for (i = 0; i < 30; i++) @(negedge sys_clk) n += (collision !== 1'b0);
    // Return on a rising edge so the next stimulus is driven there
    @(posedge sys_clk);
  endtask
  initial begin
    #1000000;
    $display("unexpected at %0t: run did not finish", $time);
    fails++;
    report_and_stop;
  end
  initial begin
    seed = 7;
    {fails, n_checks, probe, nrst, sqe_inhibit} = '0;
    pin_register_priority_strap = 1'b1;
    do_reset(1'b0);
    rd(EC2_ADDR, 16'h4003);
    rd(5'h12, 16'h0000);
    for (int k = 0; k < 12; k++) begin
      d = 16'($random(seed));
      u_mgmt_station.wr(d);
      @(posedge sys_clk);
      {link_is_100, isolate, rx_activity, line_collision} <= d[8:5];
      partner_link_fault <= d[4];
      repeat (3) @(posedge sys_clk);
      rd(EC2_ADDR, {2'b01, d[4], 11'h000, d[1:0]});
      chk({d[7] | (d[1] & d[8]), d[7] | (d[0] & !d[8]), d[6:5]});
    end
    u_mgmt_station.wr(16'h0003);
    {link_is_100, isolate, rx_activity, line_collision} <= 4'h0;
    partner_link_fault <= 1'b0;
    tx_en <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(4'h6);
    frame;
    cnt_chk(TEST_PULSE);
    chk(4'h4);
    full_duplex <= 1'b1;
    frame;
    cnt_chk(0);
    full_duplex <= 1'b0;
    sqe_inhibit <= 1'b1;
    frame;
    cnt_chk(0);
    sqe_inhibit <= 1'b0;
    $display("node tests done");
    do_reset(1'b1);
    rd(EC2_ADDR, 16'hC003);
    tx_en <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(4'h4);
    frame;
    cnt_chk(0);
    $display("repeater tests done");
    report_and_stop;
  end
endmodule
